// [common/dadc_defs.svh]
`ifndef DADC_DEFS_SVH
`define DADC_DEFS_SVH
// Function
// - sleep set: both channels stop converting, only bias stays up
// - power-down request set: lowest power state, no conversions
// - outputs enabled at power-down entry: outputs hold the last code
// - output enable high: all channel code outputs go high impedance
// - format 0 gives offset binary, format 1 two's complement, both channels
// - negative full scale: 00_0000_0000 offset, 10_0000_0000 two's complement
// - one LSB above zero: 10_0000_0001 offset, 00_0000_0001 two's complement
// - code appears five clocks after its sample edge, pipeline runs every clock in run mode
// - both channels sample on the same rising clock edge
`define DADC_WIDTH 10
`define DADC_MSB 9
`define DADC_LATENCY 5
`define DADC_ADDR_W 12
`define DADC_CTRL_OFFS 12'h000
`define DADC_STATUS_OFFS 12'h004
`define DADC_CODES_OFFS 12'h008
`define DADC_CODES_B_LSB 16
`define DADC_CTRL_RESET 4'h8
`define DADC_CTRL_W 4
`define DADC_RAW_NEG_FS 10'h000
`define DADC_RAW_ONE_UP 10'h201
`define DADC_RAW_POS_FS 10'h3FF
`define DADC_OB_NEG_FS 10'h000
`define DADC_TC_NEG_FS 10'h200
`define DADC_OB_ONE_UP 10'h201
`define DADC_TC_ONE_UP 10'h001
`define DADC_OB_POS_FS 10'h3FF
`define DADC_TC_POS_FS 10'h1FF
`endif

// [common/dadc_pkg.sv]
`include "dadc_defs.svh"
package dadc_pkg;
    typedef enum logic [1:0] {
        DADC_RUN = 2'b00,
        DADC_SLEEP = 2'b01,
        DADC_DOWN = 2'b10
    } dadc_mode_type;

    // control word, format select in bit 0
    typedef struct packed {
        logic oe_n;
        logic power_down_request;
        logic sleep;
        logic fmt;
    } dadc_ctrl_type;

    typedef struct packed {
        logic [`DADC_WIDTH-1:0] b;
        logic [`DADC_WIDTH-1:0] a;
    } dadc_codes_type;
endpackage

// [logic/dadc_pipe.sv]
`include "dadc_defs.svh"
module dadc_pipe #(
    parameter int WIDTH = `DADC_WIDTH,
    parameter int DEPTH = `DADC_LATENCY
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic advance,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage [DEPTH];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < DEPTH; i++) begin
                stage[i] <= '0;
            end
        end else if (advance) begin
            stage[0] <= din;
            for (int i = 1; i < DEPTH; i++) begin
                stage[i] <= stage[i-1];
            end
        end
    end

    assign dout = stage[DEPTH-1];
endmodule

// [logic/dadc_top.sv]
`include "dadc_defs.svh"
module dadc_top #(
    parameter int WIDTH = `DADC_WIDTH,
    parameter int LATENCY = `DADC_LATENCY
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`DADC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire dadc_pkg::dadc_codes_type raw_sample,
    output logic [WIDTH-1:0] chan_a_code,
    output logic chan_a_code_oe_n,
    output logic [WIDTH-1:0] chan_b_code,
    output logic chan_b_code_oe_n
);
    import dadc_pkg::*;

    dadc_ctrl_type ctrl;
    dadc_mode_type mode;
    dadc_mode_type next_mode;
    dadc_codes_type codes_q;
    logic run;
    logic [WIDTH-1:0] a_tail;
    logic [WIDTH-1:0] b_tail;
    logic [WIDTH-1:0] a_conv;
    logic [WIDTH-1:0] b_conv;

    // power mode: power-down outranks sleep
    assign next_mode = ctrl.power_down_request ? DADC_DOWN :
        (ctrl.sleep ? DADC_SLEEP : DADC_RUN);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= DADC_RUN;
        end else begin
            mode <= next_mode;
        end
    end

    // converters stop outside run mode; nothing moves in sleep or down
    assign run = (mode == DADC_RUN);

    // one shared advance keeps the two channels on the same sample edge
    dadc_pipe #(
        .WIDTH(WIDTH),
        .DEPTH(LATENCY)
    ) u_pipe_a (
        .pclk(pclk),
        .presetn(presetn),
        .advance(run),
        .din(raw_sample.a),
        .dout(a_tail)
    );

    dadc_pipe #(
        .WIDTH(WIDTH),
        .DEPTH(LATENCY)
    ) u_pipe_b (
        .pclk(pclk),
        .presetn(presetn),
        .advance(run),
        .din(raw_sample.b),
        .dout(b_tail)
    );

    // two's complement is offset binary with the msb turned over
    assign a_conv = {a_tail[`DADC_MSB] ^ ctrl.fmt, a_tail[`DADC_MSB-1:0]};
    assign b_conv = {b_tail[`DADC_MSB] ^ ctrl.fmt, b_tail[`DADC_MSB-1:0]};

    // output latch holds its last code whenever the converters are stopped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            codes_q <= '0;
        end else if (run) begin
            codes_q <= '{b: b_conv, a: a_conv};
        end
    end

    assign chan_a_code = codes_q.a;
    assign chan_b_code = codes_q.b;
    assign chan_a_code_oe_n = ctrl.oe_n;
    assign chan_b_code_oe_n = ctrl.oe_n;

    // register slave, zero wait states
    logic acc_phase;
    logic hit_ctrl;
    logic hit_status;
    logic hit_codes;
    logic hit_any;
    logic [31:0] rd_word;
    logic [31:0] status_word;
    logic [31:0] codes_word;

    assign acc_phase = psel && penable;
    assign hit_ctrl = (paddr == `DADC_CTRL_OFFS);
    assign hit_status = (paddr == `DADC_STATUS_OFFS);
    assign hit_codes = (paddr == `DADC_CODES_OFFS);
    assign hit_any = hit_ctrl || hit_status || hit_codes;
    assign pready = 1'b1;
    assign pslverr = acc_phase && !hit_any;

    assign status_word = {28'h0000000, !ctrl.oe_n,
        mode == DADC_DOWN, mode == DADC_SLEEP, run};
    assign codes_word = {6'h00, codes_q.b, 6'h00, codes_q.a};

    always_comb begin
        if (hit_ctrl) begin
            rd_word = {28'h0000000, ctrl};
        end else if (hit_status) begin
            rd_word = status_word;
        end else if (hit_codes) begin
            rd_word = codes_word;
        end else begin
            rd_word = 32'h00000000;
        end
    end

    // read data is latched in the setup phase so it leaves a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_word;
        end
    end

    // outputs come up in high impedance until software enables them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `DADC_CTRL_RESET;
        end else if (acc_phase && pwrite && hit_ctrl) begin
            ctrl <= pwdata[`DADC_CTRL_W-1:0];
        end
    end

    // checking: counts edges with the pipeline running in a row
    logic [2:0] run_cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_cnt <= 3'h0;
        end else if (!run) begin
            run_cnt <= 3'h0;
        end else if (run_cnt != 3'h7) begin
            run_cnt <= run_cnt + 3'h1;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_sleep_stops;
        ctrl.sleep && !ctrl.power_down_request |=>
            mode == DADC_SLEEP ##0 !run;
    endproperty
    a_sleep_stops: assert property (p_sleep_stops)
        else $error("sleep did not stop conversion");

    property p_power_down;
        ctrl.power_down_request |=> mode == DADC_DOWN;
    endproperty
    a_power_down: assert property (p_power_down)
        else $error("power-down not entered");

    property p_down_hold;
        mode == DADC_DOWN ##1 mode == DADC_DOWN |-> $stable(codes_q);
    endproperty
    a_down_hold: assert property (p_down_hold)
        else $error("code moved in power-down");

    // an enable write must reach both bus drivers on the next cycle
    property p_tristate;
        acc_phase && pwrite && hit_ctrl |=>
            chan_a_code_oe_n == $past(pwdata[`DADC_CTRL_W-1])
            && chan_b_code_oe_n == $past(pwdata[`DADC_CTRL_W-1]);
    endproperty
    a_tristate: assert property (p_tristate)
        else $error("outputs driven while disabled");

    property p_format;
        run |=> chan_a_code[`DADC_MSB-1:0] == $past(a_tail[`DADC_MSB-1:0])
            && chan_a_code[`DADC_MSB] == ($past(a_tail[`DADC_MSB])
            ^ $past(ctrl.fmt));
    endproperty
    a_format: assert property (p_format)
        else $error("format coding wrong");

    property p_neg_fs;
        run && b_tail == `DADC_RAW_NEG_FS |=> chan_b_code ==
            ($past(ctrl.fmt) ? `DADC_TC_NEG_FS : `DADC_OB_NEG_FS);
    endproperty
    a_neg_fs: assert property (p_neg_fs)
        else $error("negative full scale code");

    property p_one_up;
        run && a_tail == `DADC_RAW_ONE_UP |=> chan_a_code ==
            ($past(ctrl.fmt) ? `DADC_TC_ONE_UP : `DADC_OB_ONE_UP);
    endproperty
    a_one_up: assert property (p_one_up)
        else $error("one lsb above zero code");

    property p_pos_fs;
        run && b_tail == `DADC_RAW_POS_FS |=> chan_b_code ==
            ($past(ctrl.fmt) ? `DADC_TC_POS_FS : `DADC_OB_POS_FS);
    endproperty
    a_pos_fs: assert property (p_pos_fs)
        else $error("positive full scale code");

    property p_latency;
        run_cnt >= 3'h6 |-> chan_a_code[`DADC_MSB-1:0] ==
            $past(raw_sample.a[`DADC_MSB-1:0], 6);
    endproperty
    a_latency: assert property (p_latency)
        else $error("channel a latency wrong");

    property p_same_edge;
        run_cnt >= 3'h6 |-> chan_b_code[`DADC_MSB-1:0] ==
            $past(raw_sample.b[`DADC_MSB-1:0], 6);
    endproperty
    a_same_edge: assert property (p_same_edge)
        else $error("channel b skewed from a");

    c_stream: cover property (run_cnt == 3'h7);
    c_sleep: cover property (mode == DADC_RUN ##1 mode == DADC_SLEEP);
    c_down_hold: cover property (mode == DADC_DOWN && !ctrl.oe_n);
    c_tc_out: cover property (run && ctrl.fmt && !ctrl.oe_n);
endmodule

// [test/dadc_capture.sv]
module dadc_capture (
    input wire logic pclk,
    input wire logic [9:0] code_a,
    input wire logic oe_n_a,
    input wire logic [9:0] code_b,
    input wire logic oe_n_b,
    output logic [9:0] cap_a,
    output logic [9:0] cap_b
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] pin_a;
    logic [9:0] pin_b;
    // released bus floats: never let it look like the last code
    assign pin_a = oe_n_a ? ~cap_a : code_a;
    assign pin_b = oe_n_b ? ~cap_b : code_b;
    always_ff @(posedge pclk) begin
        cap_a <= pin_a;
        cap_b <= pin_b;
    end
endmodule

// [test/tb.sv]
`include "dadc_defs.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dadc_pkg::*;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, chan_a_code_oe_n, chan_b_code_oe_n;
    logic [9:0] chan_a_code, chan_b_code, cap_a, cap_b;
    dadc_codes_type raw_sample = '{b: `DADC_RAW_NEG_FS, a: `DADC_RAW_POS_FS};
    int fails = 0;
    int checks = 0;
    logic [9:0] rv [3] = '{`DADC_RAW_NEG_FS, `DADC_RAW_ONE_UP,
        `DADC_RAW_POS_FS};
    logic [9:0] ex [2][3] = '{
        '{`DADC_OB_NEG_FS, `DADC_OB_ONE_UP, `DADC_OB_POS_FS},
        '{`DADC_TC_NEG_FS, `DADC_TC_ONE_UP, `DADC_TC_POS_FS}};

    dadc_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .raw_sample, .chan_a_code,
        .chan_a_code_oe_n, .chan_b_code, .chan_b_code_oe_n);
    dadc_capture cap (.pclk(pclk), .code_a(chan_a_code),
        .oe_n_a(chan_a_code_oe_n), .code_b(chan_b_code),
        .oe_n_b(chan_b_code_oe_n), .cap_a(cap_a), .cap_b(cap_b));

    initial begin
        forever #10 pclk = ~pclk;
    end

    initial begin
        #20us;
        fails++;
        conclude();
    end

    task conclude;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task chk(input string n, input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask

    task t_reset;
        chk("oe_n a", chan_a_code_oe_n, 32'h1);
        apb(1'h0, `DADC_CTRL_OFFS, 32'h0);
        chk("ctrl", rd, `DADC_CTRL_RESET);
        apb(1'h0, 12'h010, 32'h0);
        chk("slverr", err, 32'h1);
        chk("unmapped", rd, 32'h0);
        $display("test reset done");
    endtask

    // new sample at edge e+1 must show only after edge e+6
    task step(input int i, input int f, input int p);
        raw_sample <= '{b: rv[(i+1)%3], a: rv[i]};
        repeat (5) @(posedge pclk);
        #1 chk("a early", chan_a_code, ex[f][p]);
        @(posedge pclk);
        #1 chk("a", chan_a_code, ex[f][i]);
        chk("b", chan_b_code, ex[f][(i+1)%3]);
        @(posedge pclk);
        #1 chk("capture", cap_a, ex[f][i]);
        chk("capture b", cap_b, ex[f][(i+1)%3]);
        @(posedge pclk);
    endtask

    task t_codes;
        int p;
        p = 2;
        apb(1'h1, `DADC_CTRL_OFFS, 32'h0);
        for (int f = 0; f < 2; f++) begin
            apb(1'h1, `DADC_CTRL_OFFS, f);
            for (int i = 0; i < 3; i++) begin
                step(i, f, p);
                p = i;
            end
        end
        $display("test codes done");
    endtask

    task t_power;
        // power-down and sleep together: power-down must win
        apb(1'h1, `DADC_CTRL_OFFS, 32'h7);
        raw_sample <= '{b: rv[1], a: rv[1]};
        repeat (8) @(posedge pclk);
        apb(1'h0, `DADC_STATUS_OFFS, 32'h0);
        chk("status down", rd, 32'hC);
        chk("hold down", chan_a_code, `DADC_TC_POS_FS);
        apb(1'h1, `DADC_CTRL_OFFS, 32'h1);
        repeat (8) @(posedge pclk);
        apb(1'h0, `DADC_CODES_OFFS, 32'h0);
        chk("codes", rd, {6'h0, `DADC_TC_ONE_UP, 6'h0, `DADC_TC_ONE_UP});
        chk("oe_n a", chan_a_code_oe_n, 32'h0);
        // sleep straight from run; new samples must not reach the bus
        apb(1'h1, `DADC_CTRL_OFFS, 32'h3);
        raw_sample <= '{b: rv[0], a: rv[0]};
        repeat (8) @(posedge pclk);
        apb(1'h0, `DADC_STATUS_OFFS, 32'h0);
        chk("status sleep", rd, 32'hA);
        chk("hold sleep", chan_b_code, `DADC_TC_ONE_UP);
        $display("test power done");
    endtask

    task t_hiz;
        apb(1'h1, `DADC_CTRL_OFFS, 32'h8);
        chk("oe_n a", chan_a_code_oe_n, 32'h1);
        chk("oe_n b", chan_b_code_oe_n, 32'h1);
        apb(1'h0, `DADC_CTRL_OFFS, 32'h0);
        chk("ctrl rw", rd, 32'h8);
        $display("test hiz done");
    endtask

    task t_rerun;
        apb(1'h1, `DADC_CTRL_OFFS, 32'h0);
        raw_sample <= '{b: rv[2], a: rv[2]};
        repeat (8) @(posedge pclk);
        #1 chk("pre reset", chan_a_code, `DADC_OB_POS_FS);
        @(posedge pclk);
        presetn <= 1'h0;
        @(posedge pclk);
        #1 chk("reset code a", chan_a_code, 32'h0);
        chk("reset oe_n b", chan_b_code_oe_n, 32'h1);
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        apb(1'h0, `DADC_CTRL_OFFS, 32'h0);
        chk("ctrl after reset", rd, `DADC_CTRL_RESET);
        $display("test rerun done");
    endtask

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        t_reset();
        t_codes();
        t_power();
        t_hiz();
        t_rerun();
        conclude();
    end
endmodule
